/* common/phy_status_defines.vh */
`ifndef PHY_STATUS_DEFINES_VH
`define PHY_STATUS_DEFINES_VH

// Clock and jabber timing
`define CLK_PERIOD_NS      10
`define JABBER_TIME_MS     105
`define NS_PER_MS          1000000
`define JABBER_CNT_W       24

// Register addresses
`define REG_ADDR_W         5
`define REG_BASIC_STATUS   5'h01
`define REG_PHY_ID_HIGH    5'h02

// Basic status bit positions
`define BS_T4              15
`define BS_ABIL_HI         14
`define BS_ABIL_LO         11
`define BS_PREAMBLE_OPT    6
`define BS_AN_COMPLETE     5
`define BS_REMOTE_FAULT    4
`define BS_AN_ABILITY      3
`define BS_LINK_STATUS     2
`define BS_JABBER          1
`define BS_EXT_CAP         0

// Identifier reset value (arbitrary, neutral)
`define PHY_ID_HIGH_RST    16'h5A5A

// Management frame layout
`define MF_PREAMBLE_LEN    6'h20
`define MF_HDR_LAST        4'hB
`define MF_DATA_LAST       4'hF
`define MF_OP_READ         2'h2
`define MF_OP_WRITE        2'h1

`endif

/* rtl/jabber_timer.v */
`include "phy_status_defines.vh"

module jabber_timer #(
   parameter                    CNT_W = `JABBER_CNT_W,
   parameter [CNT_W-1:0]        LIMIT = 24'hA037A0
) (
   input  wire                  i_core_clk,
   input  wire                  i_rst_n,
   input  wire                  i_tx_active,
   input  wire                  i_speed_10,
   output wire                  o_cutoff,
   output wire                  o_jabber_pulse
);

   reg  [CNT_W-1:0]             cnt_r;
   reg                          cutoff_r;
   reg                          pulse_r;

   assign o_cutoff       = cutoff_r;
   assign o_jabber_pulse = pulse_r;

   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_r    <= {CNT_W{1'b0}};
         cutoff_r <= 1'b0;
         pulse_r  <= 1'b0;
      end else begin
         pulse_r <= 1'b0;
         if (!i_tx_active) begin
            cnt_r    <= {CNT_W{1'b0}};
            cutoff_r <= 1'b0;
         end else if (i_speed_10 && !cutoff_r) begin
            if (cnt_r == LIMIT) begin
               cutoff_r <= 1'b1;
               pulse_r  <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // jabber_timer

/* rtl/phy_status_regs.v */
// Behaviour
// - Status bit 15 for four-pair 100 Mb/s always reads zero.
// - Status bits 14 to 11 mirror the four advertised ability bits.
// - Status bit 6 follows the preamble setting, which also makes preamble optional.
// - Status bit 5 shows that auto-negotiation has completed.
// - Status bit 4 shows partner remote fault with autoneg on, far-end fault otherwise.
// - Status bit 3 always reads one.
// - Status bit 2 shows link, latches low on failure until the status register is read.
// - A 10 Mb/s transmission longer than 105 ms is cut off and sets the jabber bit.
// - A set jabber bit with its mask bit set raises the management interrupt.
// - The jabber bit stays set until a status read, interrupt status read or reset.
// - No jabber detection happens at 100 Mb/s.
// - Status bit 0 always reads one.
// - Identifier bits 3 to 18 sit in descending order from register bit 15 down.
// - Writes to the identifier register are ignored in compatibility mode.
// - Management transactions keep working while the data path is isolated.
`include "phy_status_defines.vh"

module phy_status_regs #(
   parameter [`JABBER_CNT_W-1:0] JABBER_CYCLES =
      `JABBER_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
   input  wire                  i_core_clk,
   input  wire                  i_rst_n,
   input  wire                  i_mdc,
   input  wire                  i_mdio,
   output wire                  o_mdio,
   output wire                  o_mdio_oe_n,
   input  wire [4:0]            i_phy_addr,
   input  wire [3:0]            i_adv_ability,
   input  wire                  i_mgmt_preamble_setting,
   input  wire                  i_an_enable,
   input  wire                  i_an_complete,
   input  wire                  i_lp_remote_fault,
   input  wire                  i_far_end_fault,
   input  wire                  i_link_ok,
   input  wire                  i_isolate,
   input  wire                  i_speed_10,
   input  wire                  i_tx_active,
   input  wire                  i_irq_status_read,
   input  wire                  i_jabber_irq_mask,
   input  wire                  i_compat_mode,
   output wire                  o_tx_cutoff,
   output wire                  o_mgmt_irq
);

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_HDR   = 3'h2;
   localparam [2:0] ST_TA    = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;
   localparam [2:0] ST_WDATA = 3'h5;

   reg  [2:0]                   mdc_sync_r;
   reg  [2:0]                   mdio_sync_r;
   reg                          mdc_lvl_r;
   reg                          mdio_lvl_r;
   reg  [2:0]                   state_r;
   reg  [5:0]                   pre_cnt_r;
   reg  [3:0]                   cnt_r;
   reg  [11:0]                  hdr_r;
   reg                          is_read_r;
   reg  [15:0]                  sh_r;
   reg                          mdio_out_r;
   reg                          mdio_oe_n_r;
   reg                          status_read_r;
   reg                          link_lat_r;
   reg                          jabber_r;
   reg                          irq_r;
   reg  [15:0]                  phy_id_high_r;
   reg  [15:0]                  status_w;
   reg  [15:0]                  rd_mux_w;

   wire                         mdc_stable;
   wire                         mdc_rise;
   wire                         bit_in;
   wire [11:0]                  hdr_full;
   wire                         jabber_pulse;
   wire                         preamble_optional_flag;

   assign o_mdio      = mdio_out_r;
   assign o_mdio_oe_n = mdio_oe_n_r;
   assign o_mgmt_irq  = irq_r;

   // Change counts once second and third stage agree
   assign mdc_stable = (mdc_sync_r[1] == mdc_sync_r[2]);
   assign mdc_rise   = mdc_stable & mdc_sync_r[2] & ~mdc_lvl_r;
   assign bit_in     = (mdio_sync_r[1] == mdio_sync_r[2]) ? mdio_sync_r[2] : mdio_lvl_r;
   assign hdr_full   = {hdr_r[10:0], bit_in};

   assign preamble_optional_flag = i_mgmt_preamble_setting;

   jabber_timer #(
      .CNT_W          (`JABBER_CNT_W),
      .LIMIT          (JABBER_CYCLES)
   ) u_jabber (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .i_tx_active    (i_tx_active & ~i_isolate),
      .i_speed_10     (i_speed_10),
      .o_cutoff       (o_tx_cutoff),
      .o_jabber_pulse (jabber_pulse)
   );

   always @* begin
      status_w = 16'h0000;
      status_w[`BS_T4] = 1'b0;
      status_w[`BS_ABIL_HI:`BS_ABIL_LO] = i_adv_ability;
      status_w[`BS_PREAMBLE_OPT] = preamble_optional_flag;
      status_w[`BS_AN_COMPLETE] = i_an_complete;
      status_w[`BS_REMOTE_FAULT] = i_an_enable ? i_lp_remote_fault : i_far_end_fault;
      status_w[`BS_AN_ABILITY] = 1'b1;
      status_w[`BS_LINK_STATUS] = link_lat_r;
      status_w[`BS_JABBER] = jabber_r;
      status_w[`BS_EXT_CAP] = 1'b1;
   end

   always @* begin
      case (hdr_full[4:0])
         `REG_BASIC_STATUS: rd_mux_w = status_w;
         `REG_PHY_ID_HIGH:  rd_mux_w = phy_id_high_r;
         default:           rd_mux_w = 16'h0000;
      endcase
   end

   // Input synchronisers and filtered levels
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         mdc_sync_r  <= 3'h0;
         mdio_sync_r <= 3'h7;
         mdc_lvl_r   <= 1'b0;
         mdio_lvl_r  <= 1'b1;
      end else begin
         mdc_sync_r  <= {mdc_sync_r[1:0], i_mdc};
         mdio_sync_r <= {mdio_sync_r[1:0], i_mdio};
         if (mdc_stable) begin
            mdc_lvl_r <= mdc_sync_r[2];
         end
         if (mdio_sync_r[1] == mdio_sync_r[2]) begin
            mdio_lvl_r <= mdio_sync_r[2];
         end
      end
   end

   // Management frame engine, independent of isolation
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_r       <= ST_IDLE;
         pre_cnt_r     <= 6'h00;
         cnt_r         <= 4'h0;
         hdr_r         <= 12'h000;
         is_read_r     <= 1'b0;
         sh_r          <= 16'h0000;
         mdio_out_r    <= 1'b1;
         mdio_oe_n_r   <= 1'b1;
         status_read_r <= 1'b0;
         phy_id_high_r <= `PHY_ID_HIGH_RST;
      end else begin
         status_read_r <= 1'b0;
         if (mdc_rise) begin
            case (state_r)
               ST_IDLE: begin
                  if (bit_in) begin
                     if (pre_cnt_r != `MF_PREAMBLE_LEN) begin
                        pre_cnt_r <= pre_cnt_r + 6'h01;
                     end
                  end else begin
                     if (pre_cnt_r == `MF_PREAMBLE_LEN || preamble_optional_flag) begin
                        state_r <= ST_START;
                     end
                     pre_cnt_r <= 6'h00;
                  end
               end
               ST_START: begin
                  cnt_r   <= 4'h0;
                  state_r <= bit_in ? ST_HDR : ST_IDLE;
               end
               ST_HDR: begin
                  hdr_r <= hdr_full;
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `MF_HDR_LAST) begin
                     cnt_r <= 4'h0;
                     if (hdr_full[9:5] != i_phy_addr) begin
                        state_r <= ST_IDLE;
                     end else if (hdr_full[11:10] == `MF_OP_READ) begin
                        sh_r          <= rd_mux_w;
                        status_read_r <= (hdr_full[4:0] == `REG_BASIC_STATUS);
                        is_read_r     <= 1'b1;
                        state_r       <= ST_TA;
                     end else if (hdr_full[11:10] == `MF_OP_WRITE) begin
                        is_read_r <= 1'b0;
                        state_r   <= ST_TA;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               ST_TA: begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == 4'h0) begin
                     if (is_read_r) begin
                        mdio_out_r  <= 1'b0;
                        mdio_oe_n_r <= 1'b0;
                     end
                  end else begin
                     cnt_r <= 4'h0;
                     if (is_read_r) begin
                        mdio_out_r <= sh_r[15];
                        sh_r       <= {sh_r[14:0], 1'b0};
                        state_r    <= ST_RDATA;
                     end else begin
                        state_r <= ST_WDATA;
                     end
                  end
               end
               ST_RDATA: begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `MF_DATA_LAST) begin
                     mdio_oe_n_r <= 1'b1;
                     mdio_out_r  <= 1'b1;
                     state_r     <= ST_IDLE;
                  end else begin
                     mdio_out_r <= sh_r[15];
                     sh_r       <= {sh_r[14:0], 1'b0};
                  end
               end
               ST_WDATA: begin
                  sh_r  <= {sh_r[14:0], bit_in};
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `MF_DATA_LAST) begin
                     state_r <= ST_IDLE;
                     if (hdr_r[4:0] == `REG_PHY_ID_HIGH && !i_compat_mode) begin
                        phy_id_high_r <= {sh_r[14:0], bit_in};
                     end
                  end
               end
               default: begin
                  state_r     <= ST_IDLE;
                  mdio_oe_n_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // Latched status bits and interrupt
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         link_lat_r <= 1'b0;
         jabber_r   <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         if (!i_link_ok) begin
            link_lat_r <= 1'b0;
         end else if (status_read_r) begin
            link_lat_r <= 1'b1;
         end
         if (jabber_pulse) begin
            jabber_r <= 1'b1;
         end else if (status_read_r || i_irq_status_read) begin
            jabber_r <= 1'b0;
         end
         irq_r <= (jabber_r | jabber_pulse) & i_jabber_irq_mask;
      end
   end

endmodule // phy_status_regs

/* sim/phy_status_regs_assertions.sv */
module phy_status_regs_assertions #(
   parameter [23:0] JABBER_CYCLES = 24'h32
) (
   input wire i_core_clk,
   input wire i_rst_n,
   input wire i_tx_active,
   input wire i_speed_10,
   input wire i_isolate,
   input wire i_irq_status_read,
   input wire i_jabber_irq_mask,
   input wire o_tx_cutoff,
   input wire o_mgmt_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] run_r;
   wire         run_on = i_tx_active & i_speed_10 & ~i_isolate;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Length of the current transmit run
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !run_on) run_r <= 24'h0;
      else if (run_r != 24'hFFFFFF) run_r <= run_r + 24'h1;
   end
   property p_cut_late;
      run_r >= JABBER_CYCLES + 24'h2 |-> o_tx_cutoff;
   endproperty
   a_cut_late: assert property (p_cut_late) else $error("no cutoff");
   property p_cut_early;
      $rose(o_tx_cutoff) |-> run_r + 24'h2 >= JABBER_CYCLES;
   endproperty
   a_cut_early: assert property (p_cut_early) else $error("early cutoff");
   property p_cut_hold;
      o_tx_cutoff && i_tx_active && !i_isolate |=> o_tx_cutoff;
   endproperty
   a_cut_hold: assert property (p_cut_hold) else $error("cutoff lost");
   property p_cut_drop;
      !i_tx_active ##1 !i_tx_active |-> !o_tx_cutoff;
   endproperty
   a_cut_drop: assert property (p_cut_drop) else $error("cutoff stuck");
   property p_cut_speed;
      $rose(o_tx_cutoff) |-> $past(i_speed_10 && i_tx_active && !i_isolate);
   endproperty
   a_cut_speed: assert property (p_cut_speed) else $error("cutoff at 100");
   property p_irq_mask;
      o_mgmt_irq |-> $past(i_jabber_irq_mask);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   property p_irq_rise;
      $rose(o_tx_cutoff) && i_jabber_irq_mask |=> o_mgmt_irq;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq missing");
   property p_irq_clr;
      i_irq_status_read && !i_tx_active ##1 i_jabber_irq_mask |=> !o_mgmt_irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
endmodule // phy_status_regs_assertions

bind phy_status_regs phy_status_regs_assertions #(.JABBER_CYCLES(JABBER_CYCLES)) u_chk (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_tx_active(i_tx_active),
   .i_speed_10(i_speed_10), .i_isolate(i_isolate), .i_irq_status_read(i_irq_status_read),
   .i_jabber_irq_mask(i_jabber_irq_mask), .o_tx_cutoff(o_tx_cutoff), .o_mgmt_irq(o_mgmt_irq));

/* sim/smi_master.sv */
module smi_master (
   input  wire  i_core_clk,
   input  wire  i_dut_mdio,
   input  wire  i_dut_oe_n,
   output logic o_mdc,
   output wire  o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv_r = 1'b0;
   logic dat_r = 1'b1;
   initial o_mdc = 1'b0;
   // Pull-up holds the line high when nobody drives
   assign o_line = !i_dut_oe_n ? i_dut_mdio : (drv_r ? dat_r : 1'b1);
   task automatic tick(input logic d, input logic drv, output logic s);
      o_mdc <= 1'b0;
      dat_r <= d;
      drv_r <= drv;
      repeat (10) @(posedge i_core_clk);
      s = o_line;
      o_mdc <= 1'b1;
      repeat (10) @(posedge i_core_clk);
   endtask
   task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
         input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] hdr;
      logic        s;
      hdr = {2'h1, op, pa, ra, 2'h2, wd};
      rd = 16'h0;
      if (pre) repeat (32) tick(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         tick(hdr[i], op == 2'h1 || i > 17, s);
         if (i < 16) rd = {rd[14:0], s};
      end
      // Clock stands still low between frames
      o_mdc <= 1'b0;
      drv_r <= 1'b0;
      repeat (20) @(posedge i_core_clk);
   endtask
endmodule // smi_master

/* sim/tb_phy_status_regs.sv */
`include "phy_status_defines.vh"
module tb_phy_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [4:0] PA = 5'h0B;
   localparam int   JC = 50;
   logic clk = 1'b0, rst_n = 1'b0, pre_set = 1'b1, an_en = 1'b0, an_done = 1'b0;
   logic lp_rf = 1'b0, fe_f = 1'b0, link = 1'b1, iso = 1'b0, sp10 = 1'b0, txa = 1'b0;
   logic irq_rd = 1'b0, mask = 1'b0, compat = 1'b0, lat_link = 1'b0, lat_jab = 1'b0;
   logic [3:0] adv = 4'h0;
   logic [15:0] v, wv;
   wire mdc, line, mdio_o, oe_n, cut, irq;
   int error_cnt = 0, checks = 0;
   phy_status_regs #(.JABBER_CYCLES(24'h32)) u_dut (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_mdc(mdc), .i_mdio(line), .o_mdio(mdio_o),
      .o_mdio_oe_n(oe_n), .i_phy_addr(PA), .i_adv_ability(adv),
      .i_mgmt_preamble_setting(pre_set), .i_an_enable(an_en), .i_an_complete(an_done),
      .i_lp_remote_fault(lp_rf), .i_far_end_fault(fe_f), .i_link_ok(link),
      .i_isolate(iso), .i_speed_10(sp10), .i_tx_active(txa), .i_irq_status_read(irq_rd),
      .i_jabber_irq_mask(mask), .i_compat_mode(compat), .o_tx_cutoff(cut), .o_mgmt_irq(irq));
   smi_master u_smi (.i_core_clk(clk), .i_dut_mdio(mdio_o), .i_dut_oe_n(oe_n),
      .o_mdc(mdc), .o_line(line));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [15:0] stat();
      return {1'b0, adv, 4'h0, pre_set, an_done, an_en ? lp_rf : fe_f, 1'b1, lat_link,
              lat_jab, 1'b1};
   endfunction
   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      u_smi.frame(1'b1, 2'h2, PA, ra, 16'h0, v);
      check("read", v, exp);
      check("mdio released", 16'(oe_n), 16'h0001);
   endtask
   task automatic rd_stat();
      rd(`REG_BASIC_STATUS, stat());
      lat_link = link;
      lat_jab = 1'b0;
   endtask
   task automatic jab(input logic s10, input logic m);
      sp10 <= s10;
      mask <= m;
      txa <= 1'b1;
      repeat (JC + 10) @(posedge clk);
      check("cutoff", 16'(cut), 16'(s10));
      check("irq", 16'(irq), 16'(s10 & m));
      txa <= 1'b0;
      repeat (3) @(posedge clk);
      check("cutoff end", 16'(cut), 16'h0);
      lat_jab = lat_jab | s10;
   endtask
   initial begin
      #800000;
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(59846));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`REG_PHY_ID_HIGH, `PHY_ID_HIGH_RST);
      for (int k = 0; k < 12; k++) begin
         @(posedge clk);
         {adv, pre_set, an_en, an_done, lp_rf, fe_f, link} <= 10'($urandom);
         repeat (2) @(posedge clk);
         if (!link) lat_link = 1'b0;
         rd_stat();
      end
      link <= 1'b1;
      pre_set <= 1'b1;
      wv = 16'($urandom);
      u_smi.frame(1'b1, 2'h1, PA, `REG_PHY_ID_HIGH, wv, v);
      rd(`REG_PHY_ID_HIGH, wv);
      compat <= 1'b1;
      u_smi.frame(1'b1, 2'h1, PA, `REG_PHY_ID_HIGH, ~wv, v);
      rd(`REG_PHY_ID_HIGH, wv);
      compat <= 1'b0;
      u_smi.frame(1'b1, 2'h1, PA, `REG_BASIC_STATUS, 16'h0000, v);
      rd_stat();
      rd(5'h1F, 16'h0000);
      u_smi.frame(1'b1, 2'h2, PA ^ 5'h01, `REG_PHY_ID_HIGH, 16'h0, v);
      check("other address", v, 16'hFFFF);
      pre_set <= 1'b0;
      u_smi.frame(1'b0, 2'h2, PA, `REG_PHY_ID_HIGH, 16'h0, v);
      check("no preamble", v, 16'hFFFF);
      pre_set <= 1'b1;
      u_smi.frame(1'b0, 2'h2, PA, `REG_PHY_ID_HIGH, 16'h0, v);
      check("preamble optional", v, wv);
      jab(1'b1, 1'b1);
      rd_stat();
      rd_stat();
      jab(1'b1, 1'b1);
      irq_rd <= 1'b1;
      @(posedge clk);
      irq_rd <= 1'b0;
      repeat (3) @(posedge clk);
      check("irq cleared", 16'(irq), 16'h0);
      lat_jab = 1'b0;
      jab(1'b0, 1'b1);
      rd_stat();
      jab(1'b1, 1'b0);
      iso <= 1'b1;
      txa <= 1'b1;
      rd_stat();
      check("isolated cutoff", 16'(cut), 16'h0);
      txa <= 1'b0;
      iso <= 1'b0;
      summarize();
   end
endmodule // tb_phy_status_regs
